// ===== dcdiv_defs.svh
// constants for the dual output clock divider control block
// assumes inclusion by the design modules and the bench of this block
`ifndef DCDIV_DEFS_SVH
`define DCDIV_DEFS_SVH

// avalon byte offsets
`define DCDIV_OFS_CFG 5'h00
`define DCDIV_OFS_DIV 5'h04
`define DCDIV_OFS_DAC 5'h08
`define DCDIV_OFS_RANGE 5'h0C
`define DCDIV_OFS_STATUS 5'h10
`define DCDIV_OFS_FREQ 5'h14

// nonvolatile power-up image
`define DCDIV_CFG_RST 9'h060
`define DCDIV_DIV_RST 10'h000
`define DCDIV_DAC_RST 10'h1F4
`define DCDIV_RANGE_RST 5'h0A

// post divider value is field plus this base
`define DCDIV_DIV_BASE 11'h002
`define DCDIV_PRE_UNIT 11'h001

// status bit positions
`define DCDIV_ST_PD 0
`define DCDIV_ST_REF_DRV 1
`define DCDIV_ST_MAIN_DRV 2
`define DCDIV_ST_REF_PRE 3

// frequency figures in Hz
`define DCDIV_STEP_5K 32'h00001388
`define DCDIV_BAND_5K 32'h00271000
`define DCDIV_BAND_WIDE 32'h0030D400
`define DCDIV_BASE_DFLT 32'h01C9C380

`endif

// ===== dcdiv_pkg.sv
// types shared by the clock divider control block
// assumes dcdiv_defs.svh is on the include path
package dcdiv_pkg;

	// mode word, msb first
	typedef struct packed {
		logic main_pin_powerdown_mode;
		logic reference_pin_powerdown_mode;
		logic reference_prescale_select;
		logic reference_enable_mode;
		logic [1:0] reference_prescaler;
		logic [1:0] main_prescaler;
		logic post_divider_bypass;
	} dcdiv_cfg_s;

	typedef enum logic {
		DCDIV_GATE_OFF = 1'b0,
		DCDIV_GATE_ON = 1'b1
	} dcdiv_gate_e;

	typedef logic [10:0] dcdiv_div_t;

endpackage : dcdiv_pkg

// ===== dcdiv_stage.sv
// one divider stage: counts half periods of its input clock
// assumes run already carries the clock enable and the power-down stop
`timescale 1ns/1ps
`include "dcdiv_defs.svh"

module dcdiv_stage
	import dcdiv_pkg::*;
#(
	parameter int W = 11
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic half_tick_i,
	input wire logic [W-1:0] divisor,
	output logic level_q,
	output logic half_tick_o
);

	logic [W-1:0] cnt_q;
	logic wrap;

	// >= keeps a divisor lowered on the fly from stalling the count
	assign wrap = (divisor == '0) || (cnt_q >= divisor - W'(1));
	assign half_tick_o = run & half_tick_i & wrap;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (run && half_tick_i) begin
			cnt_q <= wrap ? '0 : cnt_q + W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (half_tick_o) begin
			level_q <= ~level_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property flip_p;
		@(posedge core_clk) disable iff (reset)
		half_tick_o |=> level_q != $past(level_q);
	endproperty
	level_flip_a: assert property (flip_p) else $error("stage level missed its toggle");

	unit_pass_a: assert property (@(posedge core_clk) disable iff (reset)
		run && half_tick_i && divisor == W'(1) |-> half_tick_o)
		else $error("divide by one dropped a half period");

endmodule : dcdiv_stage

// ===== dcdiv_top.sv
// dual output clock divider control: prescalers, post divider, output gating
// assumes core_clk stands in for the master oscillator, one half period a cycle;
// the control pins are asynchronous, the avalon master is on core_clk
//
// Summary of operation
// - reference prescaler divides master by 1,2,4,8
// - main prescaler divides independently, feeds post divider
// - post divider divides by 2 to 1025
// - bypass routes main prescaler straight out
// - 10-bit word steps master frequency
// - range step shifts band 2.56 or 3.20 MHz
// - outputs enable synchronously, no glitch, at the next falling source edge
// - settings reload nonvolatile defaults at power-up
// - all reference bits clear: output off, pin powers down
// - select only: pin picks prescaled or master clock
// - enable mode: pin high tri-states reference output
// - powerdown mode: pin high powers down, else drives
// - main pin high tri-states main output
// - main powerdown mode: pin high powers down
// - both pins' power-down requests are ORed
// - divisor field 00,01,10,11 means 1,2,4,8
`timescale 1ns/1ps
`include "dcdiv_defs.svh"

module dcdiv_top
	import dcdiv_pkg::*;
#(
	parameter logic [31:0] STEP_HZ = `DCDIV_STEP_5K,
	parameter logic [31:0] BASE_HZ = `DCDIV_BASE_DFLT
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic reference_control_pin,
	input wire logic main_control_pin,
	output logic reference_clock_output,
	output logic reference_clock_output_oe,
	output logic main_clock_output,
	output logic main_clock_output_oe
);

	localparam logic [31:0] BAND_HZ = (STEP_HZ == `DCDIV_STEP_5K) ?
		`DCDIV_BAND_5K : `DCDIV_BAND_WIDE;

	////////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic dcdiv_div_t m_of(input logic [1:0] f);
		return `DCDIV_PRE_UNIT << f;
	endfunction : m_of

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, bit 0 reference, bit 1 main

	logic [1:0] pin_meta_q;
	logic [1:0] pin_s_q;
	logic ref_s;
	logic main_s;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_meta_q <= 2'h0;
			pin_s_q <= 2'h0;
		end else if (ce) begin
			pin_meta_q <= {main_control_pin, reference_control_pin};
			pin_s_q <= pin_meta_q;
		end
	end

	assign ref_s = pin_s_q[0];
	assign main_s = pin_s_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// register file over avalon

	dcdiv_cfg_s cfg_q;
	logic [9:0] div_q;
	logic [9:0] dac_q;
	logic [4:0] range_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_val;
	logic [31:0] status;
	logic [31:0] freq_hz;
	logic [31:0] wr_cfg;
	logic [31:0] wr_div;
	logic [31:0] wr_dac;
	logic [31:0] wr_range;
	logic wr_fire;

	// answered on the second enabled edge; ce low stretches the wait, never loses a write
	assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce);
	assign avs_readdata = rdata_q;
	assign wr_fire = avs_write & ack_q & ce;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign wr_cfg = be_merge(32'(cfg_q), avs_writedata, avs_byteenable);
	assign wr_div = be_merge(32'(div_q), avs_writedata, avs_byteenable);
	assign wr_dac = be_merge(32'(dac_q), avs_writedata, avs_byteenable);
	assign wr_range = be_merge(32'(range_q), avs_writedata, avs_byteenable);

	// reset stands for power-up and reloads the stored image
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_q <= dcdiv_cfg_s'(`DCDIV_CFG_RST);
			div_q <= `DCDIV_DIV_RST;
			dac_q <= `DCDIV_DAC_RST;
			range_q <= `DCDIV_RANGE_RST;
		end else if (wr_fire) begin
			case (avs_address)
				`DCDIV_OFS_CFG: cfg_q <= dcdiv_cfg_s'(wr_cfg[$bits(dcdiv_cfg_s)-1:0]);
				`DCDIV_OFS_DIV: div_q <= wr_div[9:0];
				`DCDIV_OFS_DAC: dac_q <= wr_dac[9:0];
				`DCDIV_OFS_RANGE: range_q <= wr_range[4:0];
				default: ;
			endcase
		end
	end

	// nominal master frequency, a readback aid for software
	assign freq_hz = BASE_HZ + 32'(range_q) * BAND_HZ + 32'(dac_q) * STEP_HZ;

	always_comb begin
		case (avs_address)
			`DCDIV_OFS_CFG: rd_val = 32'(cfg_q);
			`DCDIV_OFS_DIV: rd_val = 32'(div_q);
			`DCDIV_OFS_DAC: rd_val = 32'(dac_q);
			`DCDIV_OFS_RANGE: rd_val = 32'(range_q);
			`DCDIV_OFS_STATUS: rd_val = status;
			`DCDIV_OFS_FREQ: rd_val = freq_hz;
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (ce && avs_read && !ack_q) begin
			rdata_q <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power-down and mode decode

	logic pd_ref;
	logic pd;
	logic run;
	logic mux_mode;
	logic ref_use_pre;
	logic [1:0] want;

	assign pd_ref = ref_s & (cfg_q.reference_pin_powerdown_mode |
		(~cfg_q.reference_enable_mode & ~cfg_q.reference_prescale_select));
	assign pd = pd_ref | (cfg_q.main_pin_powerdown_mode & main_s);
	// the master stops while powered down, so every divider freezes in phase
	assign run = ce & ~pd;

	assign mux_mode = ~cfg_q.reference_enable_mode & cfg_q.reference_prescale_select &
		~cfg_q.reference_pin_powerdown_mode;
	// the mux switches at once; a switch mid-period can shorten one pulse
	assign ref_use_pre = mux_mode ? ref_s : cfg_q.reference_prescale_select;

	assign want[0] = ~pd & (mux_mode | ((cfg_q.reference_enable_mode |
		cfg_q.reference_pin_powerdown_mode) & ~ref_s));
	assign want[1] = ~pd & ~main_s;

	////////////////////////////////////////////////////////////////////////////////
	// clock chain

	logic mlvl_q;
	logic [1:0] pre_lvl;
	logic [1:0] pre_tick;
	dcdiv_div_t pre_div [2];
	logic post_lvl;
	logic post_tick;
	logic [1:0] src_lvl;
	logic [1:0] src_tick;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mlvl_q <= 1'b0;
		end else if (run) begin
			mlvl_q <= ~mlvl_q;
		end
	end

	assign pre_div[0] = m_of(cfg_q.reference_prescaler);
	assign pre_div[1] = m_of(cfg_q.main_prescaler);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pre
			dcdiv_stage #(.W(11)) u_pre (
				.core_clk(core_clk),
				.reset(reset),
				.run(run),
				.half_tick_i(1'b1),
				.divisor(pre_div[g]),
				.level_q(pre_lvl[g]),
				.half_tick_o(pre_tick[g])
			);
		end
	endgenerate

	dcdiv_stage #(.W(11)) u_post (
		.core_clk(core_clk),
		.reset(reset),
		.run(run),
		.half_tick_i(pre_tick[1]),
		.divisor(11'(div_q) + `DCDIV_DIV_BASE),
		.level_q(post_lvl),
		.half_tick_o(post_tick)
	);

	assign src_lvl[0] = ref_use_pre ? pre_lvl[0] : mlvl_q;
	assign src_tick[0] = ref_use_pre ? pre_tick[0] : run;
	assign src_lvl[1] = cfg_q.post_divider_bypass ? pre_lvl[1] : post_lvl;
	assign src_tick[1] = cfg_q.post_divider_bypass ? pre_tick[1] : post_tick;

	////////////////////////////////////////////////////////////////////////////////
	// output gates: open only on a falling source edge, close on one or at once on power-down

	generate
		for (g = 0; g < 2; g++) begin : g_gate
			dcdiv_gate_e gate_q;
			logic out_q;
			logic oe_q;
			logic fall;

			assign fall = src_tick[g] & src_lvl[g];

			always_ff @(posedge core_clk) begin
				if (reset) begin
					gate_q <= DCDIV_GATE_OFF;
				end else if (ce) begin
					if (pd) begin
						gate_q <= DCDIV_GATE_OFF;
					end else begin
						case (gate_q)
							DCDIV_GATE_OFF: begin
								if (want[g] && fall) begin
									gate_q <= DCDIV_GATE_ON;
								end
							end
							DCDIV_GATE_ON: begin
								if (!want[g] && fall) begin
									gate_q <= DCDIV_GATE_OFF;
								end
							end
							default: gate_q <= DCDIV_GATE_OFF;
						endcase
					end
				end
			end

			always_ff @(posedge core_clk) begin
				if (reset) begin
					out_q <= 1'b0;
					oe_q <= 1'b0;
				end else if (ce) begin
					oe_q <= (gate_q == DCDIV_GATE_ON) & ~pd;
					out_q <= (gate_q == DCDIV_GATE_ON) & src_lvl[g];
				end
			end
		end
	endgenerate

	assign reference_clock_output = g_gate[0].out_q;
	assign reference_clock_output_oe = g_gate[0].oe_q;
	assign main_clock_output = g_gate[1].out_q;
	assign main_clock_output_oe = g_gate[1].oe_q;

	always_comb begin
		status = 32'h00000000;
		status[`DCDIV_ST_PD] = pd;
		status[`DCDIV_ST_REF_DRV] = g_gate[0].oe_q;
		status[`DCDIV_ST_MAIN_DRV] = g_gate[1].oe_q;
		status[`DCDIV_ST_REF_PRE] = ref_use_pre;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	logic ref_off_mode;
	assign ref_off_mode = ~cfg_q.reference_enable_mode & ~cfg_q.reference_prescale_select &
		~cfg_q.reference_pin_powerdown_mode;

	sequence mux_low_s;
		ce && mux_mode && !ref_s && !pd && g_gate[0].gate_q == DCDIV_GATE_ON;
	endsequence

	sequence pin_down_s;
		ce && ((ref_s && cfg_q.reference_pin_powerdown_mode) ||
			(main_s && cfg_q.main_pin_powerdown_mode));
	endsequence

	reset_image_a: assert property ($past(reset) |->
		cfg_q == dcdiv_cfg_s'(`DCDIV_CFG_RST) && dac_q == `DCDIV_DAC_RST)
		else $error("power-up image not loaded");

	pd_tristate_a: assert property (pd && ce |=>
		!reference_clock_output_oe && !main_clock_output_oe)
		else $error("output driven while powered down");

	pd_or_a: assert property (pin_down_s |=> $stable(mlvl_q) && !main_clock_output_oe)
		else $error("pin power-down did not stop the master");

	ref_hiz_a: assert property (ref_off_mode && !reference_clock_output_oe &&
		g_gate[0].gate_q == DCDIV_GATE_OFF |=> !reference_clock_output_oe)
		else $error("reference driven with all mode bits clear");

	ref_glitch_a: assert property ($rose(reference_clock_output_oe) |->
		!reference_clock_output)
		else $error("reference enabled mid pulse");

	main_glitch_a: assert property ($rose(main_clock_output_oe) |-> !main_clock_output)
		else $error("main enabled mid pulse");

	mux_follow_a: assert property (mux_low_s ##1 mux_low_s |=>
		reference_clock_output != $past(reference_clock_output))
		else $error("mux low did not pass the master clock");

	ref_hold_off_a: assert property (ce && cfg_q.reference_enable_mode &&
		!cfg_q.reference_pin_powerdown_mode && ref_s &&
		g_gate[0].gate_q == DCDIV_GATE_OFF |=> g_gate[0].gate_q == DCDIV_GATE_OFF)
		else $error("reference enabled while its pin is high");

	main_hold_off_a: assert property (ce && !cfg_q.main_pin_powerdown_mode && main_s &&
		g_gate[1].gate_q == DCDIV_GATE_OFF |=> g_gate[1].gate_q == DCDIV_GATE_OFF)
		else $error("main enabled while its pin is high");

	bypass_route_a: assert property (cfg_q.post_divider_bypass |->
		src_tick[1] == pre_tick[1] && src_lvl[1] == pre_lvl[1])
		else $error("bypass did not route the prescaler");

	band_step_a: assert property ($changed(range_q) && $stable(dac_q) |->
		freq_hz - $past(freq_hz) == (32'(range_q) - 32'($past(range_q))) * BAND_HZ)
		else $error("range step moved the band by the wrong amount");

	bus_answer_a: assert property ((avs_read || avs_write) && ce && !ack_q |=>
		!ce || !avs_waitrequest || !(avs_read || avs_write))
		else $error("bus access not answered on its second edge");

endmodule : dcdiv_top

// ===== dcdiv_host.sv
// avalon master standing in for the host controller
// assumes the slave answers with waitrequest on core_clk
`timescale 1ns/1ps

module dcdiv_host (
	input wire logic core_clk,
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
	end

	////////////////////////////////////////////////////////////////
	// waitrequest and read data are taken as they stood at the rising edge
	task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output bit ok);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		ok = (avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released data no longer shows the last value
		avs_writedata <= ~d;
	endtask : xfer
endmodule : dcdiv_host

// ===== tb_top.sv
// self-checking bench for the clock divider control block
// assumes dcdiv_host as bus master; core_clk doubles as the master clock
`timescale 1ns/1ps
`include "dcdiv_defs.svh"

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin $display("Error %s expected %0h seen %0h", nm, e, g); err_count++; end end

module tb_top;
	logic core_clk, reset, ce, ref_pin, main_pin;
	logic [4:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic reference_clock_output, reference_clock_output_oe;
	logic main_clock_output, main_clock_output_oe;
	int err_count = 0;
	int tests_run = 0;
	int seed = 34225;
	int h;
	logic [31:0] q;
	logic [9:0] e, dv, dac;
	logic [4:0] rg;
	bit bp;
	// pin/mode table: main_pin_powerdown_mode mpin en sel reference_pin_powerdown_mode rpin | ref_oe prescaled pd main_oe
	localparam logic [9:0] MODES [14] = '{10'h012, 10'h001, 10'h05D, 10'h049, 10'h091,
		10'h089, 10'h0D1, 10'h0CD, 10'h0B2, 10'h0ED, 10'h029, 10'h1CC, 10'h3C6, 10'h2CD};

	dcdiv_top dut (.core_clk(core_clk), .reset(reset), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .reference_control_pin(ref_pin),
		.main_control_pin(main_pin), .reference_clock_output(reference_clock_output),
		.reference_clock_output_oe(reference_clock_output_oe),
		.main_clock_output(main_clock_output), .main_clock_output_oe(main_clock_output_oe));

	dcdiv_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("Counts: %0d mismatches in %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic give_up;
		err_count++;
		report_and_stop();
	endtask : give_up

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		bit ok;
		host.xfer(a, 1'b1, d, r, ok);
		if (!ok) give_up();
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] r);
		bit ok;
		host.xfer(a, 1'b0, 32'h00000000, r, ok);
		if (!ok) give_up();
	endtask : rd

	function automatic logic lvl(input bit m);
		return m ? main_clock_output : reference_clock_output;
	endfunction : lvl

	// two toggles are skipped so a partial interval after a change is not counted
	task automatic half(input bit m, output int hp);
		logic p;
		int k;
		for (k = 0; k < 3; k++) begin
			hp = 0;
			p = lvl(m);
			do begin
				@(negedge core_clk);
				hp++;
			end while (lvl(m) === p && hp < 5000);
			if (hp >= 5000) give_up();
		end
	endtask : half

	function automatic int ehalf(input logic [1:0] m, input logic [9:0] d, input bit b);
		return (1 << m) * (b ? 1 : d + 2);
	endfunction : ehalf

	function automatic logic [31:0] efreq(input logic [9:0] d, input logic [4:0] r);
		return `DCDIV_BASE_DFLT + r * 32'h00271000 + d * 32'h00001388;
	endfunction : efreq

	task automatic check_image;
		rd(`DCDIV_OFS_CFG, q);
		`CHK("cfg image", 32'h00000060, q)
		rd(`DCDIV_OFS_DIV, q);
		`CHK("div image", 32'h00000000, q)
		rd(`DCDIV_OFS_DAC, q);
		`CHK("dac image", 32'h000001F4, q)
		rd(`DCDIV_OFS_RANGE, q);
		`CHK("range image", 32'h0000000A, q)
	endtask : check_image

	// glitch-free enable: output starts low and its first high is a full half period
	task automatic en_check;
		int n;
		@(posedge core_clk);
		main_pin <= 1'b1;
		repeat (20) @(posedge core_clk);
		main_pin <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (main_clock_output_oe !== 1'b1 && n < 50);
		if (n >= 50) give_up();
		`CHK("first level", 1'b0, main_clock_output)
		n = 0;
		while (main_clock_output !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 50) give_up();
		h = 0;
		while (main_clock_output === 1'b1 && h < 50) begin
			@(negedge core_clk);
			h++;
		end
		if (h >= 50) give_up();
		`CHK("first high", 2, h)
	endtask : en_check

	////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		ref_pin = 1'b0;
		main_pin = 1'b0;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		check_image();
		wr(5'h18, 32'h12345678);
		rd(5'h18, q);
		`CHK("unmapped", 32'h00000000, q)
		repeat (3) begin
			dac = 10'($random(seed));
			rg = 5'($random(seed));
			wr(`DCDIV_OFS_DAC, {22'h000000, dac});
			wr(`DCDIV_OFS_RANGE, {27'h0000000, rg});
			wr(`DCDIV_OFS_FREQ, 32'hFFFFFFFF);
			rd(`DCDIV_OFS_DAC, q);
			`CHK("dac word", {22'h000000, dac}, q)
			rd(`DCDIV_OFS_FREQ, q);
			`CHK("frequency", efreq(dac, rg), q)
		end
		for (int k = 0; k < 18; k++) begin
			dv = (k == 16) ? 10'h3FF : (k == 17) ? 10'h000 : 10'($random(seed) & 31);
			bp = (k < 16) && (k % 3 == 1);
			wr(`DCDIV_OFS_DIV, {22'h000000, dv});
			wr(`DCDIV_OFS_CFG, {23'h000000, 4'h3, k[1:0], k[3:2], bp});
			repeat (20) @(posedge core_clk);
			half(1'b0, h);
			`CHK("ref half period", 1 << k[1:0], h)
			half(1'b1, h);
			`CHK("main half period", ehalf(k[3:2], dv, bp), h)
		end
		wr(`DCDIV_OFS_DIV, 32'h00000000);
		for (int i = 0; i < 14; i++) begin
			e = MODES[i];
			wr(`DCDIV_OFS_CFG, {23'h000000, e[9], e[5], e[6], e[7], 2'h1, 2'h0, 1'b0});
			@(posedge core_clk);
			main_pin <= e[8];
			ref_pin <= e[4];
			repeat (20) @(posedge core_clk);
			@(negedge core_clk);
			`CHK("ref oe", e[3], reference_clock_output_oe)
			`CHK("main oe", e[0], main_clock_output_oe)
			rd(`DCDIV_OFS_STATUS, q);
			`CHK("power down", e[1], q[`DCDIV_ST_PD])
			`CHK("ref drive bit", e[3], q[`DCDIV_ST_REF_DRV])
			`CHK("main drive bit", e[0], q[`DCDIV_ST_MAIN_DRV])
			if (e[3]) begin
				half(1'b0, h);
				`CHK("ref mux half", e[2] ? 2 : 1, h)
			end
			if (e[0]) begin
				half(1'b1, h);
				`CHK("main drive half", 2, h)
			end
		end
		@(posedge core_clk);
		ref_pin <= 1'b0;
		main_pin <= 1'b0;
		wr(`DCDIV_OFS_CFG, 32'h00000060);
		en_check();
		en_check();
		@(posedge core_clk);
		reset <= 1'b1;
		@(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		`CHK("oe after reset", 2'h0, {reference_clock_output_oe, main_clock_output_oe})
		check_image();
		report_and_stop();
	end
endmodule : tb_top
